// >>> hw/bcd_top.v
`timescale 1ns/1ps
`include "bcd_consts.vh"
module bcd_top (
    input  wire        clock,
    input  wire        sys_rst,
    input  wire [31:0] reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    input  wire        hw_reset_req,
    input  wire        soft_reset_req,
    input  wire        flash_op_busy,
    output wire        hclk_en,
    output wire        pclk_en,
    output wire        flash_clk_en,
    output wire        quad_decoder_clk_en,
    output wire        crypto_clk_en,
    output reg         hw_reset_out,
    output reg         soft_reset_out,
    output reg         radio_core_cache_flush,
    output reg         main_cache_flush
);

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    // ratio minus one for a 2-bit power-of-two code
    function [`BCD_CNT_W-1:0] div_limit2;
        input [1:0] code;
        begin
            case (code)
                2'h0:    div_limit2 = 4'h0;
                2'h1:    div_limit2 = 4'h1;
                2'h2:    div_limit2 = 4'h3;
                default: div_limit2 = 4'h7;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // register file

    reg  [31:0] amba_q;
    reg  [31:0] rstc_q;
    wire        sel_amba = (reg_addr == `BCD_OFS_AMBA);
    wire        sel_rst  = (reg_addr == `BCD_OFS_RST);

    // writes only land on implemented bits; reserved bits 9:8 are r/w
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            amba_q <= `BCD_AMBA_RST;
            rstc_q <= `BCD_RST_RST;
        end else begin
            if (reg_wr && sel_amba)
                amba_q <= reg_wdata & `BCD_AMBA_WMASK;
            if (reg_wr && sel_rst)
                rstc_q <= reg_wdata & `BCD_RST_WMASK;
        end
    end

    // read data one cycle after strobe, unmapped reads zero
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd && sel_amba) begin
            reg_rdata <= amba_q;
        end else if (reg_rd && sel_rst) begin
            reg_rdata <= rstc_q;
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // divided clock enables

    wire [2:0] hdiv_code = amba_q[`BCD_HDIV_HI:`BCD_HDIV_LO];
    wire [1:0] pdiv_code = amba_q[`BCD_PDIV_HI:`BCD_PDIV_LO];
    wire [1:0] fdiv_code = amba_q[`BCD_FLASH_DIV_HI:`BCD_FLASH_DIV_LO];

    reg  [`BCD_CNT_W-1:0] hcnt_q;
    reg  [`BCD_CNT_W-1:0] pcnt_q;
    reg  [`BCD_CNT_W-1:0] fcnt_q;
    reg  [`BCD_CNT_W-1:0] hlim_q;
    reg  [`BCD_CNT_W-1:0] plim_q;
    reg  [`BCD_CNT_W-1:0] flim_q;
    reg                   fen_q;
    reg                   qen_q;
    reg                   cen_q;
    wire [`BCD_CNT_W-1:0] hlim_d = hdiv_code[2] ? 4'hf : div_limit2(hdiv_code[1:0]);
    wire [`BCD_CNT_W-1:0] plim_d = div_limit2(pdiv_code);
    wire [`BCD_CNT_W-1:0] flim_d = div_limit2(fdiv_code);

    wire h_tick = (hcnt_q == hlim_q);
    wire p_tick = h_tick && (pcnt_q == plim_q);
    wire f_tick = (fcnt_q == flim_q);

    // new ratios and gates only take effect at a period boundary, so no
    // derived clock ever sees a shortened high or low phase
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            hcnt_q <= 4'h0;
            pcnt_q <= 4'h0;
            fcnt_q <= 4'h0;
            hlim_q <= 4'h3;
            plim_q <= 4'h3;
            flim_q <= 4'h0;
            fen_q  <= 1'b0;
            qen_q  <= 1'b0;
            cen_q  <= 1'b0;
        end else begin
            if (h_tick) begin
                hcnt_q <= 4'h0;
                hlim_q <= hlim_d;
                qen_q  <= amba_q[`BCD_QUADRATURE_DECODER_EN_BIT];
                cen_q  <= amba_q[`BCD_CRYPTO_EN_BIT];
                if (pcnt_q == plim_q) begin
                    pcnt_q <= 4'h0;
                    plim_q <= plim_d;
                end else begin
                    pcnt_q <= pcnt_q + 4'h1;
                end
            end else begin
                hcnt_q <= hcnt_q + 4'h1;
            end
            if (f_tick) begin
                fcnt_q <= 4'h0;
                flim_q <= flim_d;
                fen_q  <= amba_q[`BCD_FLASH_EN_BIT];
            end else begin
                fcnt_q <= fcnt_q + 4'h1;
            end
        end
    end

    // enables are one source-clock pulse per derived period
    assign hclk_en             = h_tick;
    assign pclk_en             = p_tick;
    assign flash_clk_en        = f_tick && fen_q;
    assign quad_decoder_clk_en = h_tick && qen_q;
    assign crypto_clk_en       = h_tick && cen_q;

    ////////////////////////////////////////////////////////////////////////////
    // reset sequencing

    // request and busy come from other domains: two-stage sync each
    reg  [1:0] hw_sync_q;
    reg  [1:0] sw_sync_q;
    reg  [1:0] busy_sync_q;
    reg        hw_pend_q;
    reg        sw_prev_q;
    wire       hw_req   = hw_sync_q[1];
    wire       sw_req   = sw_sync_q[1];
    wire       busy     = busy_sync_q[1];
    wire       defer_on = rstc_q[`BCD_DEFER_BIT];
    wire       sw_rise  = sw_req && !sw_prev_q;

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            hw_sync_q   <= 2'h0;
            sw_sync_q   <= 2'h0;
            busy_sync_q <= 2'h0;
            sw_prev_q   <= 1'b0;
        end else begin
            hw_sync_q   <= {hw_sync_q[0], hw_reset_req};
            sw_sync_q   <= {sw_sync_q[0], soft_reset_req};
            busy_sync_q <= {busy_sync_q[0], flash_op_busy};
            sw_prev_q   <= sw_req;
        end
    end

    // a hardware request is latched so a short pulse is not lost while deferred
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            hw_pend_q    <= 1'b0;
            hw_reset_out <= 1'b0;
        end else begin
            if (hw_req)
                hw_pend_q <= 1'b1;
            else if (hw_reset_out)
                hw_pend_q <= 1'b0;
            hw_reset_out <= (hw_req || hw_pend_q) && !(defer_on && busy);
        end
    end

    // software reset passes straight through, never held off by flash busy
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            soft_reset_out         <= 1'b0;
            radio_core_cache_flush <= 1'b0;
            main_cache_flush       <= 1'b0;
        end else begin
            soft_reset_out <= sw_req;
            radio_core_cache_flush <= ((hw_req || hw_pend_q) && !(defer_on && busy)) ||
                                      (sw_rise && rstc_q[`BCD_RADIO_FLUSH_BIT]);
            main_cache_flush <= ((hw_req || hw_pend_q) && !(defer_on && busy)) ||
                                (sw_rise && rstc_q[`BCD_MAIN_FLUSH_BIT]);
        end
    end

endmodule

// >>> inc/bcd_consts.vh
`ifndef BCD_CONSTS_VH
`define BCD_CONSTS_VH
// register byte addresses, compared against the full 32-bit reg_addr
`define BCD_ADDR_W          32
`define BCD_OFS_AMBA        32'h50000000
`define BCD_OFS_RST         32'h5000000c
// bus clock divider and gates fields
`define BCD_FLASH_EN_BIT    12
`define BCD_FLASH_DIV_HI    11
`define BCD_FLASH_DIV_LO    10
`define BCD_QUADRATURE_DECODER_EN_BIT     7
`define BCD_CRYPTO_EN_BIT   6
`define BCD_PDIV_HI         5
`define BCD_PDIV_LO         4
`define BCD_HDIV_HI         2
`define BCD_HDIV_LO         0
`define BCD_AMBA_RST        32'h00000022
`define BCD_AMBA_WMASK      32'h00001ff7
// reset control fields
`define BCD_RADIO_FLUSH_BIT 2
`define BCD_MAIN_FLUSH_BIT  1
`define BCD_DEFER_BIT       0
`define BCD_RST_RST         32'h00000000
`define BCD_RST_WMASK       32'h00000007
// divider counter width, largest ratio 16
`define BCD_CNT_W           4
`endif

// >>> tb/bcd_checker.sv
`timescale 1ns/1ps
module bcd_checker (
    input wire        clock,
    input wire        sys_rst,
    input wire        reg_rd,
    input wire [31:0] reg_rdata,
    input wire        hclk_en,
    input wire        pclk_en,
    input wire        quad_decoder_clk_en,
    input wire        crypto_clk_en,
    input wire        hw_reset_out,
    input wire        radio_core_cache_flush,
    input wire        main_cache_flush
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // fifteen idle cycles is the longest legal gap at divide by 16
    sequence hclk_quiet;
        (!hclk_en)[*8] ##1 (!hclk_en)[*7];
    endsequence
    a_pclk_on_hclk: assert property (pclk_en |-> hclk_en)
        else $error("pclk pulse without hclk");
    a_hclk_gap_max: assert property (hclk_quiet |=> hclk_en)
        else $error("hclk gap above 16");
    a_quad_gate_hclk: assert property (quad_decoder_clk_en |-> hclk_en)
        else $error("decoder clock off grid");
    a_crypto_gate_hclk: assert property (crypto_clk_en |-> hclk_en)
        else $error("crypto clock off grid");
    a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside slot");
    a_radio_hw_flush: assert property (hw_reset_out |-> radio_core_cache_flush)
        else $error("radio cache not flushed");
    a_main_hw_flush: assert property (hw_reset_out |-> main_cache_flush)
        else $error("main cache not flushed");
    a_soft_flush_pulse: assert property (main_cache_flush && !hw_reset_out |=> !main_cache_flush || hw_reset_out)
        else $error("soft flush wider than one cycle");
endmodule
bind bcd_top bcd_checker u_chk (.clock, .sys_rst, .reg_rd, .reg_rdata, .hclk_en, .pclk_en, .quad_decoder_clk_en,
    .crypto_clk_en, .hw_reset_out, .radio_core_cache_flush, .main_cache_flush);

// >>> tb/bcd_top_tb_top.sv
`timescale 1ns/1ps
`include "bcd_consts.vh"
module bcd_top_tb_top;
    reg clock = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, hw_reset_req = 0, soft_reset_req = 0, flash_op_busy = 0;
    reg [31:0] reg_addr = 0, reg_wdata = 0;
    wire [31:0] reg_rdata;
    wire hclk_en, pclk_en, flash_clk_en, qd, cr, hw_o, sw_o, rf, mf;
    wire [2:0] en = {flash_clk_en, pclk_en, hclk_en};
    integer fail_count = 0, checks = 0, cyc = 0, seed = 32'hfca3, am = 32'h22, i, k, nr, nm;
    bcd_top uut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hw_reset_req(hw_reset_req), .soft_reset_req(soft_reset_req),
        .flash_op_busy(flash_op_busy), .hclk_en(hclk_en), .pclk_en(pclk_en), .flash_clk_en(flash_clk_en),
        .quad_decoder_clk_en(qd), .crypto_clk_en(cr), .hw_reset_out(hw_o), .soft_reset_out(sw_o),
        .radio_core_cache_flush(rf), .main_cache_flush(mf));
    initial forever #5 clock = ~clock;
    ////////////////////////////////////////////////////////////////
    task results;
        if (fail_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // hang guard, run needs a few thousand cycles
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin fail_count++; results; end
    end
    task chk(input [31:0] g, input [31:0] e);
        checks++;
        if (g !== e) begin fail_count++; $display("ERROR %0t got %h exp %h", $time, g, e); end
    endtask
    task tick; @(posedge clock); #1; endtask
    task wr(input [31:0] a, input [31:0] d);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1; tick; reg_wr <= 0;
    endtask
    task rd(input [31:0] a, input [31:0] e);
        reg_addr <= a; reg_rd <= 1; tick; reg_rd <= 0; chk(reg_rdata, e);
    endtask
    // pulse spacing of one enable, in source cycles
    task per(input integer s, input integer e);
        integer n;
        repeat (140) tick;
        while (!en[s]) tick;
        tick; n = 1;
        while (!en[s]) begin tick; n++; end
        chk(n, e);
    endtask
    initial begin
        repeat (10) @(posedge clock);
        sys_rst <= 0; tick;
        rd(`BCD_OFS_AMBA, `BCD_AMBA_RST);
        rd(`BCD_OFS_RST, `BCD_RST_RST);
        for (i = 0; i < 6; i++) begin
            am = $random(seed);
            wr(`BCD_OFS_AMBA, am); rd(`BCD_OFS_AMBA, am & `BCD_AMBA_WMASK);
            wr(`BCD_OFS_RST, am); rd(`BCD_OFS_RST, am & `BCD_RST_WMASK);
            rd(32'h50000004, 0);
        end
        for (i = 0; i < 8; i++) begin wr(`BCD_OFS_AMBA, i); per(0, 1 << (i > 3 ? 4 : i)); per(1, 1 << (i > 3 ? 4 : i)); end
        for (i = 0; i < 4; i++) begin wr(`BCD_OFS_AMBA, 32'h1 | i << 4); per(1, 2 << i); end
        for (i = 0; i < 4; i++) begin wr(`BCD_OFS_AMBA, 32'h1000 | i << 10); per(2, 1 << i); end
        wr(`BCD_OFS_AMBA, 0); repeat (140) tick; chk({flash_clk_en, qd, cr}, 0);
        wr(`BCD_OFS_AMBA, 32'h80); repeat (20) tick; chk({qd, cr}, 2'b10);
        wr(`BCD_OFS_AMBA, 32'h40); repeat (20) tick; chk({qd, cr}, 2'b01);
        for (k = 0; k < 4; k++) begin
            wr(`BCD_OFS_RST, k << 1); soft_reset_req <= 1; nr = 0; nm = 0;
            repeat (8) begin tick; nr += rf; nm += mf; end
            chk(nr * 2 + nm, k);
            chk(sw_o, 1);
            soft_reset_req <= 0; repeat (6) tick;
        end
        hw_reset_req <= 1; repeat (3) tick; chk({hw_o, rf, mf}, 3'b111);
        hw_reset_req <= 0; repeat (6) tick; chk(hw_o, 0);
        wr(`BCD_OFS_RST, 1); flash_op_busy <= 1; repeat (3) tick;
        hw_reset_req <= 1; repeat (8) tick; chk(hw_o, 0);
        flash_op_busy <= 0; repeat (4) tick; chk(hw_o, 1);
        hw_reset_req <= 0; repeat (6) tick;
        results;
    end
endmodule
